// *** common/sequencer_pkg.sv ***
`default_nettype none
package sequencer_pkg;
   // Clock rates and the slow wake tick derived from the system clock
   localparam int CLK_HZ   = 100_000_000;
   localparam int SLOW_HZ  = 32_000;
   localparam int SLOW_DIV = CLK_HZ / SLOW_HZ;   // System cycles per slow tick
   localparam int DIV_W    = 12;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SLOW_DIV - 1);

   // Fuse array geometry
   localparam int FUSE_BITS  = 6144;
   localparam int FUSE_BYTES = FUSE_BITS / 8;
   localparam int FUSE_AW    = 10;
   localparam logic [7:0] FUSE_BLANK = 8'h00;    // Unprogrammed byte value

   // Fuse bytes pulled in during boot
   localparam logic [FUSE_AW-1:0] FUSE_BASE = 10'h000;  // Power manager trim
   localparam logic [1:0] IDX_TRIM = 2'h1;
   localparam logic [1:0] IDX_PKG  = 2'h2;
   localparam logic [1:0] IDX_MEM  = 2'h3;

   // Boot sequence states
   typedef enum logic [5:0] {
      B_OFF   = 6'h01,
      B_REG   = 6'h02,
      B_FUSE  = 6'h04,
      B_CORES = 6'h08,
      B_CRYSTAL_OSCILLATOR  = 6'h10,
      B_CPU   = 6'h20
   } boot_state_t;
endpackage
`default_nettype wire

// *** common/fuse_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface fuse_if;
   import sequencer_pkg::*;
   logic [FUSE_AW-1:0] rd_addr;   // Read address, sampled each edge
   logic [7:0]         rd_data;   // Byte at last edge's address
   logic               wr_en;     // Program strobe
   logic [FUSE_AW-1:0] wr_addr;   // Program address
   logic [7:0]         wr_data;   // Bits to set to one
   modport owner (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport array (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface
`default_nettype wire

// *** hdl/fuse_array.sv ***
`timescale 1ns/10ps
`default_nettype none
module fuse_array
   import sequencer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Array access
   fuse_if.array    fuse
);
   // Fuse cells survive reset; reset only clears the read register and the old_byte/old_addr check registers
   // Blank array reads all zero; only the program port below ever writes a cell
   logic [7:0] mem [FUSE_BYTES] = '{default: FUSE_BLANK};
   logic [7:0] old_byte;          // Value before the last program cycle
   logic [FUSE_AW-1:0] old_addr;

   // Programming can only set bits, so a blown bit stays blown
   always_ff @(posedge clk) begin
      if (fuse.wr_en) begin
         mem[fuse.wr_addr] <= mem[fuse.wr_addr] | fuse.wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fuse.rd_data <= FUSE_BLANK;
         old_byte     <= FUSE_BLANK;
         old_addr     <= '0;
      end else begin
         fuse.rd_data <= mem[fuse.rd_addr];
         old_byte     <= mem[fuse.wr_addr];
         old_addr     <= fuse.wr_addr;
      end
   end

   // A programmed one never falls back to zero
   fuse_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
      fuse.wr_en |=> ((mem[old_addr] & old_byte) == old_byte))
      else $error("fuse bit returned to zero");
endmodule
`default_nettype wire

// *** hdl/hibernate_wake_boot_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module hibernate_wake_boot_sequencer
   import sequencer_pkg::*;
#(
   parameter int WAKE_W = 32
)(
   // Clock and always-on reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // Deep sleep control from software
   input  wire logic              wake_count_load,
   input  wire logic [WAKE_W-1:0] wake_count_in,
   input  wire logic              sleep_request,
   output logic                   power_enable_drive,
   output logic                   sleep_active,
   // Power start inputs and regulator status
   input  wire logic              power_enable_in,
   input  wire logic              wake_request_input,
   input  wire logic              core_regulator_ok,
   input  wire logic              io_regulator_3v3_ok,
   // Power switches and boot releases
   output logic                   application_core_power,
   output logic                   wlan_core_power,
   output logic                   crystal_oscillator_enable,
   output logic                   application_cpu_boot,
   output logic                   wlan_cpu_boot,
   // Configuration loaded from fuses
   output logic [7:0]             power_manager_trim,
   output logic [7:0]             package_select,
   output logic [7:0]             memory_size_select,
   // Fuse access from software
   input  wire logic [FUSE_AW-1:0] fuse_rd_addr,
   output logic [7:0]             fuse_rd_data,
   output logic                   fuse_ready,
   input  wire logic              fuse_prog_en,
   input  wire logic [FUSE_AW-1:0] fuse_prog_addr,
   input  wire logic [7:0]        fuse_prog_data
);
   // Whole state of the block
   typedef struct packed {
      // Always-on sleep unit
      logic              drive;      // Power enable drive level
      logic              sleeping;   // Wake timer running
      logic              loaded;     // Wake count has been written
      logic [WAKE_W-1:0] wake_count; // Programmed wake count
      logic [WAKE_W-1:0] left;       // Slow ticks still to wait
      logic [DIV_W-1:0]  pre;        // Slow tick prescaler
      // Switched domain, rebuilt on every power-up
      boot_state_t       boot;
      logic [1:0]        idx;        // Fuse load step
      logic [7:0]        trim;
      logic [7:0]        pkg;
      logic [7:0]        mem;
      // Output flags, registered so every pin comes from a flip-flop
      logic              cores_on;   // Core power switches closed
      logic              crystal_oscillator_on;    // Crystal oscillator running
      logic              cpus_go;    // CPUs released, fuses open to software
   } state_t;

   state_t st;       // Registered state
   state_t next_st;  // Next state
   logic   chip_on;  // Either start input high
   logic   tick;     // Last system cycle of a slow period

   fuse_if fuse ();

   // Fuse storage
   fuse_array u_fuse (
      .clk  (clk),
      .nrst (nrst),
      .fuse (fuse.array)
   );

   assign chip_on = power_enable_in | wake_request_input;
   assign tick    = st.sleeping && (st.pre == DIV_LAST);

   // Boot steals the read port while loading; software owns it otherwise
   assign fuse.rd_addr = (st.boot == B_FUSE) ? FUSE_BASE + FUSE_AW'(st.idx) : fuse_rd_addr;
   // Burning only once the CPUs are running, never mid-boot
   assign fuse.wr_en   = fuse_prog_en && (st.boot == B_CPU);
   assign fuse.wr_addr = fuse_prog_addr;
   assign fuse.wr_data = fuse_prog_data;

   // Next state of sleep unit and boot sequencer
   always_comb begin
      next_st = st;
      // Wake count is only latched while idle so a running timer is untouched
      if (wake_count_load && !st.sleeping) begin
         next_st.wake_count = wake_count_in;
         next_st.loaded     = 1'b1;
      end
      if (!st.sleeping) begin
         // A zero count or missing load leaves the request without effect
         if (sleep_request && st.loaded && (st.wake_count != '0)) begin
            next_st.sleeping = 1'b1;
            next_st.drive    = 1'b0;
            next_st.left     = st.wake_count;
            next_st.pre      = '0;
         end
      end else begin
         // Further requests are ignored until the drive goes high again
         next_st.pre = tick ? '0 : st.pre + 1'b1;
         if (tick) begin
            next_st.left = st.left - 1'b1;
            if (st.left == WAKE_W'(1)) begin
               next_st.sleeping = 1'b0;
               next_st.drive    = 1'b1;
            end
         end
      end

      // Power loss wipes the switched domain; it is rebuilt on the next start
      if (!chip_on) begin
         next_st.boot = B_OFF;
         next_st.idx  = '0;
         next_st.trim = FUSE_BLANK;
         next_st.pkg  = FUSE_BLANK;
         next_st.mem  = FUSE_BLANK;
      end else begin
         unique case (st.boot)
            B_OFF: begin
               next_st.boot = B_REG;
            end
            B_REG: begin
               if (core_regulator_ok && io_regulator_3v3_ok) begin
                  next_st.boot = B_FUSE;
                  next_st.idx  = '0;
               end
            end
            B_FUSE: begin
               // Read data lags the address by one cycle
               next_st.idx = st.idx + 1'b1;
               unique case (st.idx)
                  IDX_TRIM: next_st.trim = fuse.rd_data;
                  IDX_PKG:  next_st.pkg  = fuse.rd_data;
                  IDX_MEM: begin
                     next_st.mem  = fuse.rd_data;
                     next_st.boot = B_CORES;
                  end
                  default: ;
               endcase
            end
            B_CORES: begin
               next_st.boot = B_CRYSTAL_OSCILLATOR;
            end
            B_CRYSTAL_OSCILLATOR: begin
               next_st.boot = B_CPU;
            end
            B_CPU: begin
               next_st.boot = B_CPU;
            end
            default: next_st.boot = B_OFF;
         endcase
      end

      // Flags track the state they stand beside, so they move on the same edge
      next_st.cores_on = next_st.boot inside {B_CORES, B_CRYSTAL_OSCILLATOR, B_CPU};
      next_st.crystal_oscillator_on  = next_st.boot inside {B_CRYSTAL_OSCILLATOR, B_CPU};
      next_st.cpus_go  = (next_st.boot == B_CPU);
   end

   // State register; the sleep unit powers up with the chip enabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st            <= '0;
         st.drive      <= 1'b1;
         st.boot       <= B_OFF;
         st.trim       <= FUSE_BLANK;
         st.pkg        <= FUSE_BLANK;
         st.mem        <= FUSE_BLANK;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign power_enable_drive        = st.drive;
   assign sleep_active              = st.sleeping;
   assign application_core_power    = st.cores_on;
   assign wlan_core_power           = st.cores_on;
   assign crystal_oscillator_enable = st.crystal_oscillator_on;
   assign application_cpu_boot      = st.cpus_go;
   assign wlan_cpu_boot             = st.cpus_go;
   assign fuse_ready                = st.cpus_go;
   assign fuse_rd_data              = fuse.rd_data;
   assign power_manager_trim        = st.trim;
   assign package_select            = st.pkg;
   assign memory_size_select        = st.mem;

   // Helper: length of each low period against the programmed count
   logic [WAKE_W+DIV_W-1:0] low_len;
   logic [WAKE_W+DIV_W-1:0] exp_len;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         low_len <= '0;
         exp_len <= '0;
      end else begin
         low_len <= st.drive ? '0 : low_len + 1'b1;
         if (!st.sleeping && next_st.sleeping) begin
            exp_len <= (WAKE_W+DIV_W)'(st.wake_count) * (WAKE_W+DIV_W)'(SLOW_DIV);
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   sleep_entry_a: assert property (!st.sleeping && sleep_request && st.loaded && st.wake_count != '0
      |=> !power_enable_drive ##1 !power_enable_drive)
      else $error("sleep request did not drop power enable");
   low_length_a: assert property ($rose(power_enable_drive) |-> low_len == exp_len)
      else $error("power enable low for wrong length");
   release_a: assert property (tick && st.left == WAKE_W'(1) |=> power_enable_drive && !sleep_active)
      else $error("power enable not released at count end");
   ignore_req_a: assert property (st.sleeping && !tick && sleep_request |=> st.left == $past(st.left))
      else $error("sleep request restarted running timer");
   boot_start_a: assert property (st.boot == B_OFF && chip_on |=> st.boot == B_REG)
      else $error("boot did not start");
   reg_wait_a: assert property (st.boot == B_REG && chip_on && !(core_regulator_ok && io_regulator_3v3_ok)
      |=> st.boot == B_REG)
      else $error("boot left regulator wait early");
   fuse_load_a: assert property ($rose(st.boot == B_FUSE) ##0 chip_on[*4] |=> st.boot == B_CORES)
      else $error("fuse load not four cycles");
   order_a: assert property ($rose(crystal_oscillator_enable) |-> $past(application_core_power)
      && !application_cpu_boot ##1 (application_cpu_boot || !$past(chip_on)))
      else $error("power-up order broken");
   state_lost_a: assert property (!chip_on |=> st.boot == B_OFF && !application_core_power
      && power_manager_trim == FUSE_BLANK)
      else $error("switched state survived power loss");
endmodule
`default_nettype wire

// *** verification/power_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
// Board wiring and regulators seen by the sequencer
module power_partner (
   // Clock
   input  wire logic clk,
   // Supply requests
   input  wire logic power_enable_drive,
   input  wire logic wake_request_input,
   // Supply feedback
   output logic      power_enable_in,
   output logic      core_regulator_ok,
   output logic      io_regulator_3v3_ok
);
   logic [3:0] up = 4'h0;  // Cycles since supply came on
   logic       on;         // Supply requested

   // Enable drive looped back to the enable input
   assign power_enable_in = power_enable_drive;
   assign on = power_enable_in | wake_request_input;

   // Regulators settle at different times, so a wait on one alone shows up
   always_ff @(posedge clk) begin
      if (!on) begin
         up <= 4'h0;
      end else if (up != 4'hf) begin
         up <= up + 4'h1;
      end
   end
   assign core_regulator_ok   = on && (up >= 4'h3);
   assign io_regulator_3v3_ok = on && (up >= 4'h8);
endmodule
`default_nettype wire

// *** verification/hibernate_wake_boot_sequencer_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module hibernate_wake_boot_sequencer_bench;
   import sequencer_pkg::*;
   logic clk, nrst, load, req, pe_in, wake, core_ok, io_ok;
   logic pe_drv, slp, app_pwr, wl_pwr, crystal_oscillator, app_boot, wl_boot, rdy, prog;
   logic [31:0] count;
   logic [7:0]  trim, pkg, mem, rdata, pdata;
   logic [9:0]  raddr, paddr;
   int          miscompares, total_checks, cycles, n;

   // Device under test
   hibernate_wake_boot_sequencer dut (.clk(clk), .nrst(nrst), .wake_count_load(load),
      .wake_count_in(count), .sleep_request(req), .power_enable_drive(pe_drv),
      .sleep_active(slp), .power_enable_in(pe_in), .wake_request_input(wake),
      .core_regulator_ok(core_ok), .io_regulator_3v3_ok(io_ok),
      .application_core_power(app_pwr), .wlan_core_power(wl_pwr),
      .crystal_oscillator_enable(crystal_oscillator), .application_cpu_boot(app_boot),
      .wlan_cpu_boot(wl_boot), .power_manager_trim(trim), .package_select(pkg),
      .memory_size_select(mem), .fuse_rd_addr(raddr), .fuse_rd_data(rdata),
      .fuse_ready(rdy), .fuse_prog_en(prog), .fuse_prog_addr(paddr),
      .fuse_prog_data(pdata));

   // Board and regulators
   power_partner board (.clk(clk), .power_enable_drive(pe_drv), .wake_request_input(wake),
      .power_enable_in(pe_in), .core_regulator_ok(core_ok), .io_regulator_3v3_ok(io_ok));

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, well above the sleep run of some 6300 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step();
      @(negedge clk);
   endtask

   // Program one byte, then read it back
   task automatic prog_rd(input logic [9:0] a, input logic [7:0] d, input logic [7:0] exp);
      prog = 1'b1;
      paddr = a;
      pdata = d;
      step();
      prog = 1'b0;
      raddr = a;
      step();
      check("fuse byte", {8'h00, exp}, {8'h00, rdata});
   endtask

   // Boot from power on: regulators, fuses, cores, crystal, CPUs
   task automatic boot_run(input logic [7:0] t, input logic [7:0] p, input logic [7:0] m);
      n = 0;
      while (core_ok !== 1'b1 && n < 50) begin
         n++;
         step();
      end
      check("cores before io ok", 16'h0000, {io_ok, app_pwr});
      while (app_pwr !== 1'b1 && n < 50) begin
         n++;
         step();
      end
      check("cores on", 16'h8000, {wl_pwr, crystal_oscillator, app_boot, wl_boot, 12'h000});
      check("pkg and mem", {p, m}, {pkg, mem});
      check("trim", {8'h00, t}, {8'h00, trim});
      step();
      check("crystal", 16'h0002, {crystal_oscillator, app_boot});
      step();
      check("cpu boot", 16'h0007, {app_boot, wl_boot, rdy});
   endtask

   // Fuse blank reads, set-only programming, last byte
   task automatic fuse_run();
      raddr = 10'h2ff;
      step();
      step();
      check("blank last byte", 16'h0000, {8'h00, rdata});
      prog_rd(10'h005, 8'ha5, 8'ha5);
      prog_rd(10'h005, 8'h5a, 8'hff);
      prog_rd(10'h005, 8'h00, 8'hff);
      prog_rd(10'h000, 8'h3c, 8'h3c);
      prog_rd(10'h001, 8'h81, 8'h81);
      prog_rd(10'h002, 8'h07, 8'h07);
   endtask

   // Deep sleep for two slow ticks with stray requests and a wake input
   task automatic sleep_run();
      load = 1'b1;
      count = 32'h0;
      step();
      load = 1'b0;
      req = 1'b1;
      step();
      req = 1'b0;
      step();
      check("zero count refused", 16'h0001, {15'h0, pe_drv});
      load = 1'b1;
      count = 32'h2;
      step();
      load = 1'b0;
      req = 1'b1;
      step();
      req = 1'b0;
      n = 0;
      while (pe_drv === 1'b0 && n < 7000) begin
         n++;
         load = (n == 100);
         req = (n == 101);
         count = 32'h5;
         wake = (n >= 300 && n < 330);
         if (n == 200) begin
            check("sleeping", 16'h0001, {app_pwr, crystal_oscillator, app_boot, slp});
         end
         if (n == 325) begin
            check("wake input boot", 16'h0001, {15'h0, app_pwr});
         end
         step();
      end
      check("sleep length", 16'd6250, n[15:0]);
      check("released", 16'h0002, {pe_drv, slp});
      boot_run(8'h3c, 8'h81, 8'h07);
   endtask

   // Main sequence
   initial begin
      nrst = 1'b0;
      load = 1'b0;
      req = 1'b0;
      wake = 1'b0;
      count = 32'h0;
      prog = 1'b0;
      paddr = 10'h000;
      pdata = 8'h00;
      raddr = 10'h000;
      repeat (5) step();
      nrst = 1'b1;
      boot_run(8'h00, 8'h00, 8'h00);
      fuse_run();
      sleep_run();
      end_sim();
   end
endmodule
`default_nettype wire
